// ==== i2cms_pkg.sv ====
// Package for the I2C master start and clock arbitration block.
// Assumes a single AHB-Lite slave with 32-bit word registers.
package i2cms_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL2 = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_RELOAD = 8'h08;
    localparam logic [7:0] OFF_TXBUF = 8'h0C;
    // Control two fields
    localparam int START_REQ_BIT = 0;
    localparam int CTRL2_LOCK_W = 5;
    // Status fields, reload width and reset value, bus transfer type
    localparam int STAT_START_BIT = 3;
    localparam int STAT_BCOL_BIT = 4;
    localparam int STAT_WRITE_COLLISION_FLAG_BIT = 5;
    localparam int STAT_BUSY_BIT = 6;
    localparam int STAT_SCL_HELD_BIT = 7;
    localparam int RELOAD_W = 7;
    localparam logic [6:0] RELOAD_RST = 7'h04;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b0_0001,
        ST_SETUP = 5'b0_0010,
        ST_HOLD = 5'b0_0100,
        ST_DONE = 5'b0_1000,
        ST_ARB = 5'b1_0000
    } i2cms_state_e;

    typedef struct packed {
        logic scl;
        logic sda;
    } i2cms_lines_s;
endpackage : i2cms_pkg

// ==== i2cms_sync.sv ====
// Two flip-flop synchroniser for the bus lines.
// Assumes the lines idle high when nobody drives them.
`timescale 1ns/1ns
module i2cms_sync #(
    parameter int W = 2
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta <= {W{1'b1}};
            q <= {W{1'b1}};
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule : i2cms_sync

// ==== i2cms_top.sv ====
// I2C master start generation with clock arbitration, AHB-Lite registers.
// Assumes open-drain lines with pull-ups and a single AHB-Lite master.
// Notes on behaviour
// [R1] Released clock line: counter waits until clock is seen high.
// [R2] On clock seen high, counter reloads from 7-bit reload value.
// [R3] Clock high time lasts one full counter period after seen high; code only counts it, scl_oe stays 0.
// [R4] Software sets start request, bit 0 of control register two.
// [R5] Start request with both lines high reloads counter and counts.
// [R6] Both lines high at expiry: data driven low, forming the Start.
// [R7] Start generation sets status bit 3.
// [R8] Second expiry clears start request, halts counter, keeps data low.
// [R9] Lines low at start or clock low early: collision flag, abort, idle.
// [R10] Transmit buffer write during Start sets write collision, no store.
// [R11] Low five bits of control two ignore writes until Start completes.
// [R12] Lines are only driven low or released.
`timescale 1ns/1ns
module i2cms_top (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Clock line
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    // Data line
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // Release of clock line from later bit phases
    input wire logic scl_release
);
    i2cms_pkg::i2cms_lines_s raw_lines;
    i2cms_pkg::i2cms_lines_s lines;
    i2cms_pkg::i2cms_state_e state;
    i2cms_pkg::i2cms_state_e next_state;
    logic [6:0] reload;
    logic [6:0] count;
    logic running;
    logic expire;
    logic [4:0] ctrl2_low;
    logic start_flag;
    logic bcol_flag;
    logic write_collision_flag_flag;
    logic [7:0] txbuf;
    logic arb_wait;
    logic rel_sync;
    logic rel_meta;
    logic idle_col;
    // Address phase capture
    logic dp_write;
    logic [7:0] dp_addr;
    logic dp_valid;

    assign raw_lines.scl = scl_i;
    assign raw_lines.sda = sda_i;

    i2cms_sync #(.W(2)) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .d(raw_lines),
        .q(lines)
    );

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rel_meta <= 1'b0;
            rel_sync <= 1'b0;
        end else begin
            rel_meta <= scl_release;
            rel_sync <= rel_meta;
        end
    end

    // Open-drain: output value is always low, only the data enable moves; the clock enable is held at 0
    assign scl_o = 1'b0; // [R12]
    assign sda_o = 1'b0; // [R12]
    assign scl_oe = 1'b0; // [R12]

    function automatic logic is_busy(input i2cms_pkg::i2cms_state_e s);
        is_busy = (s != i2cms_pkg::ST_IDLE) && (s != i2cms_pkg::ST_ARB);
    endfunction : is_busy

    assign expire = running && (count == 7'h00);

    // Bus slave: zero wait states, OKAY always
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_valid <= 1'b0;
            dp_write <= 1'b0;
            dp_addr <= 8'h00;
        end else if (hready) begin
            dp_valid <= hsel && (htrans == i2cms_pkg::HTRANS_NONSEQ);
            dp_write <= hwrite;
            dp_addr <= haddr;
        end
    end

    logic wr_ctrl2;
    logic wr_txbuf;
    logic wr_reload;
    logic wr_status;
    assign wr_ctrl2 = dp_valid && dp_write && (dp_addr == i2cms_pkg::OFF_CTRL2);
    assign wr_txbuf = dp_valid && dp_write && (dp_addr == i2cms_pkg::OFF_TXBUF);
    assign wr_reload = dp_valid && dp_write && (dp_addr == i2cms_pkg::OFF_RELOAD);
    assign wr_status = dp_valid && dp_write && (dp_addr == i2cms_pkg::OFF_STATUS);

    // Read data is registered at the address phase so it stands in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (hready && hsel && !hwrite) begin
            unique case (haddr)
                i2cms_pkg::OFF_CTRL2: hrdata <= {27'h000_0000, ctrl2_low};
                i2cms_pkg::OFF_STATUS: hrdata <= {24'h00_0000, !lines.scl, is_busy(state),
                                                  write_collision_flag_flag, bcol_flag, start_flag, 3'h0};
                i2cms_pkg::OFF_RELOAD: hrdata <= {25'h000_0000, reload};
                i2cms_pkg::OFF_TXBUF: hrdata <= {24'h00_0000, txbuf};
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reload <= i2cms_pkg::RELOAD_RST;
        end else if (wr_reload) begin
            reload <= hwdata[i2cms_pkg::RELOAD_W-1:0];
        end
    end

    // Buffer write during a Start is dropped
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            txbuf <= 8'h00;
        end else if (wr_txbuf && !is_busy(state)) begin // [R10]
            txbuf <= hwdata[7:0];
        end
    end

    // Control two: hardware clear of the start request beats a software write; it can meet one
    // only at an idle collision, since writes are locked out while a Start runs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl2_low <= 5'h00;
        end else if (state == i2cms_pkg::ST_DONE && expire) begin
            ctrl2_low[i2cms_pkg::START_REQ_BIT] <= 1'b0; // [R8]
        end else if (idle_col || (next_state == i2cms_pkg::ST_IDLE && state != i2cms_pkg::ST_IDLE
                     && state != i2cms_pkg::ST_ARB)) begin
            ctrl2_low[i2cms_pkg::START_REQ_BIT] <= 1'b0; // [R9]
        end else if (wr_ctrl2 && !is_busy(state)) begin // [R11]
            ctrl2_low <= hwdata[i2cms_pkg::CTRL2_LOCK_W-1:0]; // [R4]
        end
    end

    // Status flags: hardware set wins over a software write of zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            start_flag <= 1'b0;
            bcol_flag <= 1'b0;
            write_collision_flag_flag <= 1'b0;
        end else begin
            if (state == i2cms_pkg::ST_SETUP && next_state == i2cms_pkg::ST_HOLD) begin
                start_flag <= 1'b1; // [R7]
            end else if (wr_status) begin
                start_flag <= hwdata[i2cms_pkg::STAT_START_BIT];
            end
            if (idle_col || (state != i2cms_pkg::ST_IDLE && next_state == i2cms_pkg::ST_IDLE
                && state != i2cms_pkg::ST_DONE && state != i2cms_pkg::ST_ARB)) begin
                bcol_flag <= 1'b1; // [R9]
            end else if (wr_status) begin
                bcol_flag <= hwdata[i2cms_pkg::STAT_BCOL_BIT];
            end
            if (wr_txbuf && is_busy(state)) begin
                write_collision_flag_flag <= 1'b1; // [R10]
            end else if (wr_status) begin
                write_collision_flag_flag <= hwdata[i2cms_pkg::STAT_WRITE_COLLISION_FLAG_BIT];
            end
        end
    end

    logic start_go;
    assign start_go = ctrl2_low[i2cms_pkg::START_REQ_BIT];

    always_comb begin
        next_state = state;
        unique case (state)
            i2cms_pkg::ST_IDLE: begin
                if (start_go) begin
                    if (lines.scl && lines.sda) begin
                        next_state = i2cms_pkg::ST_SETUP; // [R5]
                    end else if (!lines.scl && !lines.sda) begin
                        next_state = i2cms_pkg::ST_IDLE; // [R9]
                    end
                end else if (rel_sync) begin
                    next_state = i2cms_pkg::ST_ARB;
                end
            end
            i2cms_pkg::ST_SETUP: begin
                if (!lines.scl) begin
                    next_state = i2cms_pkg::ST_IDLE; // [R9]
                end else if (expire) begin
                    next_state = lines.sda ? i2cms_pkg::ST_HOLD : i2cms_pkg::ST_IDLE; // [R6]
                end
            end
            i2cms_pkg::ST_HOLD: next_state = i2cms_pkg::ST_DONE;
            i2cms_pkg::ST_DONE: begin
                if (expire) begin
                    next_state = i2cms_pkg::ST_IDLE; // [R8]
                end
            end
            i2cms_pkg::ST_ARB: begin
                if (!rel_sync) begin
                    next_state = i2cms_pkg::ST_IDLE;
                end
            end
            default: next_state = i2cms_pkg::ST_IDLE;
        endcase
    end

    // Lines both low at request time counts as a collision: flag it and drop the request
    assign idle_col = state == i2cms_pkg::ST_IDLE && start_go && !lines.scl && !lines.sda; // [R9]

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= i2cms_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Bit-rate counter; arbitration keeps it frozen while the clock is held low
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count <= 7'h00;
            running <= 1'b0;
            arb_wait <= 1'b0;
        end else begin
            if ((state == i2cms_pkg::ST_IDLE && next_state == i2cms_pkg::ST_SETUP)
                || state == i2cms_pkg::ST_HOLD) begin
                count <= reload; // [R5] [R8]
                running <= 1'b1;
            end else if (state == i2cms_pkg::ST_ARB) begin
                if (!lines.scl) begin
                    arb_wait <= 1'b1; // [R1]
                    running <= 1'b0;
                end else if (arb_wait || !running) begin
                    arb_wait <= 1'b0;
                    count <= reload; // [R2] [R3]
                    running <= 1'b1;
                end else if (expire) begin
                    count <= reload;
                end else begin
                    count <= count - 7'h01;
                end
            end else if (expire || next_state == i2cms_pkg::ST_IDLE) begin
                running <= 1'b0; // [R8]
            end else if (running) begin
                count <= count - 7'h01;
            end
        end
    end

    // Data line pulled low from Start until software takes over
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sda_oe <= 1'b0;
        end else if (next_state == i2cms_pkg::ST_HOLD || state == i2cms_pkg::ST_HOLD
                     || state == i2cms_pkg::ST_DONE) begin
            sda_oe <= 1'b1; // [R6] [R8]
        end else if (next_state == i2cms_pkg::ST_IDLE && state == i2cms_pkg::ST_SETUP) begin
            sda_oe <= 1'b0; // [R9]
        end else if (start_go && state == i2cms_pkg::ST_IDLE) begin
            sda_oe <= 1'b0;
        end
    end

    a_start_flag_set: assert property (@(posedge hclk) disable iff (!hresetn) // [R7]
        (state == i2cms_pkg::ST_HOLD) |-> start_flag)
        else $error("start flag not set after start");
    a_sda_low_done: assert property (@(posedge hclk) disable iff (!hresetn) // [R8]
        (state == i2cms_pkg::ST_DONE) |-> sda_oe)
        else $error("data line released during start hold");
    a_req_cleared: assert property (@(posedge hclk) disable iff (!hresetn) // [R8]
        (state == i2cms_pkg::ST_DONE && expire) |=> !start_go && state == i2cms_pkg::ST_IDLE)
        else $error("start request not cleared");
    a_scl_col: assert property (@(posedge hclk) disable iff (!hresetn) // [R9]
        (state == i2cms_pkg::ST_SETUP && !lines.scl) |=> bcol_flag && !sda_oe)
        else $error("collision not flagged");
    a_idle_col: assert property (@(posedge hclk) disable iff (!hresetn) // [R9]
        idle_col |=> bcol_flag && !start_go && state == i2cms_pkg::ST_IDLE)
        else $error("collision at request not handled");
    a_write_collision_flag_set: assert property (@(posedge hclk) disable iff (!hresetn) // [R10]
        (wr_txbuf && is_busy(state)) |=> write_collision_flag_flag && $stable(txbuf))
        else $error("write collision not handled");
    a_ctrl_lock: assert property (@(posedge hclk) disable iff (!hresetn) // [R11]
        (wr_ctrl2 && is_busy(state)) |=> $stable(ctrl2_low[4:1]))
        else $error("control written during start");
    a_arb_freeze: assert property (@(posedge hclk) disable iff (!hresetn) // [R1]
        (state == i2cms_pkg::ST_ARB && !lines.scl) |=> !running)
        else $error("counter ran with clock held low");
    a_arb_reload: assert property (@(posedge hclk) disable iff (!hresetn) // [R2]
        (state == i2cms_pkg::ST_ARB && arb_wait && lines.scl) |=> running && count == $past(reload))
        else $error("counter not reloaded after clock high");
    a_open_drain: assert property (@(posedge hclk) disable iff (!hresetn) // [R12]
        !sda_o && !scl_o)
        else $error("line driven high");

    c_start_done: cover property (@(posedge hclk) disable iff (!hresetn)
        state == i2cms_pkg::ST_DONE && expire);
    c_collision: cover property (@(posedge hclk) disable iff (!hresetn) $rose(bcol_flag));
    c_write_collision_flag: cover property (@(posedge hclk) disable iff (!hresetn) $rose(write_collision_flag_flag));
    c_arb: cover property (@(posedge hclk) disable iff (!hresetn) $fell(arb_wait));
endmodule : i2cms_top

// ==== i2cms_bus_model.sv ====
// Model of the I2C bus beyond the block: pull-ups, other masters, a stretching slave.
// Assumes the bench commands holds and the free clock of another master.
`timescale 1ns/1ns
module i2cms_bus_model (
    // From the block
    input wire logic scl_oe,
    input wire logic sda_oe,
    // From the bench
    input wire logic hold_scl,
    input wire logic hold_sda,
    input wire logic run_clk,
    // Resolved lines
    output i2cms_pkg::i2cms_lines_s lines
);
    logic ext_low;
    initial begin
        ext_low = 1'b0;
        #7;
        // Other master clock, 400 ns period, stands still outside frames
        forever begin
            #200;
            ext_low = run_clk ? !ext_low : 1'b0;
        end
    end
    // Wired-AND with pull-ups: any party pulling low wins
    assign lines.scl = !(scl_oe || hold_scl || ext_low);
    assign lines.sda = !(sda_oe || hold_sda);
endmodule : i2cms_bus_model

// ==== i2cms_top_tb.sv ====
// Self-checking bench for the I2C start generation block.
// Assumes the bus model stands for every other party on the lines.
`timescale 1ns/1ns
module i2cms_top_tb;
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic [31:0] exp;
    } i2cms_row_s;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, rd;
    logic scl_o, scl_oe, sda_o, sda_oe, scl_release, hold_scl, hold_sda, run_clk;
    i2cms_pkg::i2cms_lines_s lines;
    int n_errors, checks, n;
    i2cms_row_s rows [4];
    assign hready = hreadyout;
    i2cms_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .scl_i(lines.scl), .scl_o(scl_o), .scl_oe(scl_oe),
        .sda_i(lines.sda), .sda_o(sda_o), .sda_oe(sda_oe), .scl_release(scl_release));
    i2cms_bus_model u_bus (.scl_oe(scl_oe), .sda_oe(sda_oe), .hold_scl(hold_scl),
        .hold_sda(hold_sda), .run_clk(run_clk), .lines(lines));
    initial begin
        hclk = 1'b0;
        forever #25 hclk = !hclk;
    end
    task stop_test;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : stop_test
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task wait_rdy;
        int k;
        k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (hready !== 1'b1 && k < 100);
        if (k >= 100) begin
            n_errors++;
            stop_test;
        end
    endtask : wait_rdy
    // One single word transfer; read data taken at the data phase's closing edge
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= i2cms_pkg::HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= w;
        wait_rdy;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy;
        rd = hrdata;
    endtask : bus
    task rst;
        hresetn <= 1'b0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
    endtask : rst
    task lines_ok;
        chk({scl_oe, scl_o, sda_o, hresp}, 4'h0);
    endtask : lines_ok
    initial begin
        {hsel, hwrite, hold_scl, hold_sda, run_clk, scl_release} = 6'h00;
        {haddr, htrans, hwdata} = '0;
        hsize = 3'h2;
        hresetn = 1'b0;
        n_errors = 0;
        checks = 0;
        rows[0] = {i2cms_pkg::OFF_RELOAD, 32'h0000_007F, 32'h0000_007F};
        rows[1] = {i2cms_pkg::OFF_RELOAD, 32'hFFFF_FF85, 32'h0000_0005};
        rows[2] = {i2cms_pkg::OFF_TXBUF, 32'h0000_01A5, 32'h0000_00A5};
        rows[3] = {8'h10, 32'hFFFF_FFFF, 32'h0000_0000};
        rst;
        chk(sda_oe, 1'b0);
        bus(1'b0, i2cms_pkg::OFF_RELOAD, 32'h0);
        chk(rd, {25'h0, i2cms_pkg::RELOAD_RST});
        bus(1'b0, i2cms_pkg::OFF_STATUS, 32'h0);
        chk(rd, 32'h0000_0000);
        foreach (rows[i]) begin
            bus(1'b1, rows[i].addr, rows[i].wdata);
            bus(1'b0, rows[i].addr, 32'h0);
            chk(rd, rows[i].exp);
        end
        // Start with reload 20, both lines high
        bus(1'b1, i2cms_pkg::OFF_RELOAD, 32'h0000_0014);
        bus(1'b1, i2cms_pkg::OFF_CTRL2, 32'h0000_0001);
        n = 0;
        while (sda_oe !== 1'b1 && n < 200) begin
            @(posedge hclk);
            n++;
        end
        chk(n >= 20 && n <= 28, 1'b1);
        lines_ok;
        bus(1'b0, i2cms_pkg::OFF_STATUS, 32'h0);
        chk(rd & 32'h0000_0048, 32'h0000_0048);
        bus(1'b1, i2cms_pkg::OFF_TXBUF, 32'h0000_0033);
        bus(1'b1, i2cms_pkg::OFF_CTRL2, 32'h0000_0000);
        bus(1'b0, i2cms_pkg::OFF_CTRL2, 32'h0);
        chk(rd[0], 1'b1);
        n = 0;
        do begin
            bus(1'b0, i2cms_pkg::OFF_CTRL2, 32'h0);
            n++;
        end while (rd[0] !== 1'b0 && n < 50);
        chk(n > 1 && n < 50, 1'b1);
        chk({sda_oe, lines.sda, lines.scl}, 3'b101);
        bus(1'b0, i2cms_pkg::OFF_STATUS, 32'h0);
        chk(rd & 32'h0000_0068, 32'h0000_0028);
        bus(1'b0, i2cms_pkg::OFF_TXBUF, 32'h0);
        chk(rd, 32'h0000_00A5);
        // Reset after the Start, with the data line still held low, releases it
        rst;
        chk(sda_oe, 1'b0);
        // Clock pulled low by another party before the data line falls
        bus(1'b1, i2cms_pkg::OFF_CTRL2, 32'h0000_0001);
        hold_scl <= 1'b1;
        repeat (10) @(posedge hclk);
        chk(sda_oe, 1'b0);
        bus(1'b0, i2cms_pkg::OFF_STATUS, 32'h0);
        chk(rd & 32'h0000_0058, 32'h0000_0010);
        hold_scl <= 1'b0;
        rst;
        // Both lines already low at the request
        hold_scl <= 1'b1;
        hold_sda <= 1'b1;
        bus(1'b1, i2cms_pkg::OFF_CTRL2, 32'h0000_0001);
        repeat (12) @(posedge hclk);
        chk(sda_oe, 1'b0);
        bus(1'b0, i2cms_pkg::OFF_STATUS, 32'h0);
        chk(rd & 32'h0000_0058, 32'h0000_0010);
        bus(1'b0, i2cms_pkg::OFF_CTRL2, 32'h0);
        chk(rd[0], 1'b0);
        // Software clears the flags by writing zero
        bus(1'b1, i2cms_pkg::OFF_STATUS, 32'h0);
        bus(1'b0, i2cms_pkg::OFF_STATUS, 32'h0);
        chk(rd & 32'h0000_0038, 32'h0000_0000);
        {hold_scl, hold_sda} <= 2'b00;
        rst;
        // Released clock stretched by another master: no data line activity
        scl_release <= 1'b1;
        run_clk <= 1'b1;
        repeat (40) @(posedge hclk);
        chk(sda_oe, 1'b0);
        lines_ok;
        run_clk <= 1'b0;
        scl_release <= 1'b0;
        repeat (10) @(posedge hclk);
        stop_test;
    end
    initial begin
        repeat (20000) @(posedge hclk);
        n_errors++;
        stop_test;
    end
endmodule : i2cms_top_tb
